// file: design/wwd_pkg.sv
package wwd_pkg;
   // Core clock and the internal time base that all window timers count
   localparam int CLK_NS = 5;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int TICKS_PER_S = 1000000000 / TICK_NS;
   // Ceiling on the open window, in seconds and in ticks
   localparam int OPEN_MAX_S = 640;
   localparam logic [31:0] OPEN_MAX_TICKS = 32'(OPEN_MAX_S * TICKS_PER_S);
   // Pin configurations of the device family
   localparam int CFG_ONE_SEL = 0;
   localparam int CFG_TWO_SEL = 1;
   localparam int CFG_EN_PIN = 2;
   // Close-window scaling against the sensed capacitor count (79.2 : 39.6 : 9.9 = 8 : 4 : 1)
   localparam int SHIFT_SEL0 = 3;
   localparam int SHIFT_SEL1 = 2;
   localparam int SHIFT_SEL2 = 0;
   localparam logic [1:0] SEL_DISABLE = 2'h1;
   // Register byte offsets on APB
   localparam logic [7:0] OFS_RATIO = 8'h00;
   localparam logic [7:0] OFS_CLOSE_FIX = 8'h04;
   localparam logic [7:0] OFS_GRACE = 8'h08;
   localparam logic [7:0] OFS_FAULT_TIME = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // Field layout of the ratio register: three (n-1) values of 9 bits
   localparam int RATIO_W = 9;
   localparam int RATIO_LSB0 = 0;
   localparam int RATIO_LSB1 = 9;
   localparam int RATIO_LSB2 = 18;
   // Field layout of the status register
   localparam int ST_STATE_LSB = 0;
   localparam int ST_FAULT_LSB = 6;
   localparam int ST_CAPERR_BIT = 8;
   localparam int ST_ACTIVE_BIT = 9;
   localparam int ST_CAPCNT_LSB = 16;
   // Reset values, in ticks where they are times
   localparam logic [26:0] RST_RATIO = 27'h0008_0601;
   localparam logic [31:0] RST_CLOSE_FIX = 32'h0000_2710;
   localparam logic [31:0] RST_GRACE = 32'h0000_0000;
   localparam logic [31:0] RST_FAULT_TIME = 32'h0000_07d0;
   // Last fault kinds
   localparam logic [1:0] FLT_NONE = 2'h0;
   localparam logic [1:0] FLT_EARLY = 2'h1;
   localparam logic [1:0] FLT_LATE = 2'h2;
   // Controller states, one-hot
   typedef enum logic [5:0] {
      ST_MEAS = 6'h01,
      ST_IDLE = 6'h02,
      ST_GRACE = 6'h04,
      ST_CLOSE = 6'h08,
      ST_OPEN = 6'h10,
      ST_FAULT = 6'h20
   } wwd_state_t;
endpackage

// file: design/wwd_top.sv
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Functional notes
// - Monitor only with supply, manual reset high, enabled
// - Frame is close window then open window
// - Open-window falling kick restarts a new frame
// - Kick during close window is early fault
// - No kick in whole frame is late fault
// - Fault holds output low for fault time
// - Capacitor measured once at power-up, then stored
// - One select pin: scale 79.2 or 39.6
// - Two selects: 79.2, 39.6, 9.9; 01 disables
// - Open window equals close times (n-1)
// - Open window clamped to 640 seconds
// - Up to three ratios chosen by selects
// - Enable pin high enables, low disables, anytime
// - Two selects without enable: 01 disables
// - Bad capacitor disables watchdog, overrides pins
// - Disable aborts frame, output stays released
// - On enable, enter close window at once
// - Grace period after power-up and fault end; enable-pin variant resets straight into close window
// - Select change altering timing restarts frame
// - With enable pin, code 01 acts as 00
module wwd_top import wwd_pkg::*; #(
   parameter int PIN_CFG = CFG_TWO_SEL,
   parameter int CAP_W = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Supervisory inputs
   input wire logic supply_valid,
   input wire logic manual_reset_n,
   // Watchdog pins
   input wire logic kick_input,
   input wire logic watchdog_enable_pin,
   input wire logic ratio_select_lo,
   input wire logic ratio_select_hi,
   output logic fault_output_n,
   // Close-window capacitor: charge drive out, threshold comparator in
   output logic close_window_cap_pin,
   input wire logic cap_above_thresh
);
   // Refuse configurations the decoder cannot serve
   if (PIN_CFG < CFG_ONE_SEL || PIN_CFG > CFG_EN_PIN || CAP_W < 4 || CAP_W > 24) begin : g_chk
      $error("wwd_top: unsupported PIN_CFG or CAP_W");
   end

   localparam logic [CAP_W-1:0] CAP_MAX = '1;

   // All state of the block in one record
   typedef struct packed {
      wwd_state_t st;
      logic [7:0] presc;
      logic [31:0] tmr;
      logic kick_s1;
      logic kick_s2;
      logic kick_s3;
      logic [CAP_W-1:0] cap_cnt;
      logic cap_err;
      logic charge;
      logic [26:0] ratio;
      logic [31:0] close_fix;
      logic [31:0] grace;
      logic [31:0] fault_time;
      logic [31:0] prev_close;
      logic [31:0] prev_open;
      logic prev_en;
      logic [1:0] last_fault;
      logic [31:0] rdata;
      logic fault_n;
   } wwd_regs_t;

   wwd_regs_t q; // Registered state
   wwd_regs_t d; // Next state

   logic tick; // One cycle per time-base period
   logic kick_fall; // Synchronised falling edge of the kick
   logic sel_en; // Enable as decoded from pins
   logic active; // Monitoring allowed
   logic [1:0] sel_idx; // Which of the three ratios
   logic [31:0] close_ticks; // Close-window length in ticks
   logic [31:0] open_ticks; // Open-window length in ticks
   logic [RATIO_W-1:0] ratio_m1; // Selected n-1
   logic [40:0] open_full; // Unclamped open window
   logic cfg_change; // Timing or enable moved since last cycle
   logic wr_en; // APB write access phase
   logic rd_setup; // APB read setup phase
   logic addr_ok; // Address decodes to a register

   // Decode select pins into ratio index and pin enable per variant
   always_comb begin
      sel_idx = 2'h0;
      sel_en = 1'b1;
      if (PIN_CFG == CFG_ONE_SEL) begin
         sel_idx = {1'b0, ratio_select_lo};
      end else if (PIN_CFG == CFG_TWO_SEL) begin
         // Code 01 is the disable code here; 10 and 11 pick ratios 1 and 2
         sel_en = ({ratio_select_hi, ratio_select_lo} != SEL_DISABLE);
         sel_idx = ratio_select_hi ? {ratio_select_lo, ~ratio_select_lo} : 2'h0;
      end else begin
         // Enable pin rules; 01 folds onto 00
         sel_en = watchdog_enable_pin;
         sel_idx = ratio_select_hi ? {ratio_select_lo, ~ratio_select_lo} : 2'h0;
      end
   end

   // Close and open window lengths from the stored capacitor count or the fixed value
   always_comb begin
      if (PIN_CFG == CFG_EN_PIN) begin
         close_ticks = q.close_fix;
      end else if (sel_idx == 2'h0) begin
         close_ticks = 32'(q.cap_cnt) << SHIFT_SEL0;
      end else if (sel_idx == 2'h1) begin
         close_ticks = 32'(q.cap_cnt) << SHIFT_SEL1;
      end else begin
         close_ticks = 32'(q.cap_cnt) << SHIFT_SEL2;
      end
      if (sel_idx == 2'h0) begin
         ratio_m1 = q.ratio[RATIO_LSB0 +: RATIO_W];
      end else if (sel_idx == 2'h1) begin
         ratio_m1 = q.ratio[RATIO_LSB1 +: RATIO_W];
      end else begin
         ratio_m1 = q.ratio[RATIO_LSB2 +: RATIO_W];
      end
      open_full = 41'(close_ticks) * 41'(ratio_m1);
      // Clamp keeps a large capacitor from running past the ceiling
      open_ticks = (open_full > 41'(OPEN_MAX_TICKS)) ? OPEN_MAX_TICKS : open_full[31:0];
   end

   // Bad capacitor overrides whatever the pins say
   assign active = supply_valid && manual_reset_n && sel_en && !q.cap_err;
   assign tick = (q.presc == 8'(TICK_CYC - 1));
   assign kick_fall = q.kick_s3 && !q.kick_s2;
   assign cfg_change = (close_ticks != q.prev_close) || (open_ticks != q.prev_open)
      || (active != q.prev_en);

   // APB decode: zero wait states, read data latched in the setup cycle
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   always_comb begin
      if (paddr == OFS_RATIO || paddr == OFS_CLOSE_FIX || paddr == OFS_GRACE) begin
         addr_ok = 1'b1;
      end else if (paddr == OFS_FAULT_TIME || paddr == OFS_STATUS) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = q.rdata;
   assign fault_output_n = q.fault_n;
   assign close_window_cap_pin = q.charge;

   // Next-state logic for the whole block
   always_comb begin
      d = q;
      // Time-base prescaler runs freely
      d.presc = tick ? 8'h00 : q.presc + 8'h01;
      // Two-stage synchroniser, third stage only for the edge
      d.kick_s1 = kick_input;
      d.kick_s2 = q.kick_s1;
      d.kick_s3 = q.kick_s2;
      d.prev_close = close_ticks;
      d.prev_open = open_ticks;
      d.prev_en = active;
      if (tick && q.st != ST_MEAS) begin
         d.tmr = q.tmr + 32'h1;
      end

      // Register writes; status is read-only
      if (wr_en) begin
         if (paddr == OFS_RATIO) begin
            d.ratio = pwdata[26:0];
         end else if (paddr == OFS_CLOSE_FIX) begin
            d.close_fix = pwdata;
         end else if (paddr == OFS_GRACE) begin
            d.grace = pwdata;
         end else if (paddr == OFS_FAULT_TIME) begin
            d.fault_time = pwdata;
         end
      end
      // Read mux, sampled in the setup cycle
      if (rd_setup) begin
         if (paddr == OFS_RATIO) begin
            d.rdata = {5'h00, q.ratio};
         end else if (paddr == OFS_CLOSE_FIX) begin
            d.rdata = q.close_fix;
         end else if (paddr == OFS_GRACE) begin
            d.rdata = q.grace;
         end else if (paddr == OFS_FAULT_TIME) begin
            d.rdata = q.fault_time;
         end else if (paddr == OFS_STATUS) begin
            d.rdata = 32'h0;
            d.rdata[ST_STATE_LSB +: 6] = q.st;
            d.rdata[ST_FAULT_LSB +: 2] = q.last_fault;
            d.rdata[ST_CAPERR_BIT] = q.cap_err;
            d.rdata[ST_ACTIVE_BIT] = active;
            d.rdata[ST_CAPCNT_LSB +: 16] = 16'(q.cap_cnt);
         end else begin
            d.rdata = 32'h0;
         end
      end

      // Watchdog controller
      case (q.st)
         ST_MEAS: begin
            // One charge then one discharge; the count is kept until power cycles
            if (q.charge) begin
               if (cap_above_thresh) begin
                  d.charge = 1'b0;
               end else if (q.cap_cnt == CAP_MAX) begin
                  // Open-ended charge: too large or shorted
                  d.charge = 1'b0;
                  d.cap_err = 1'b1;
               end else if (tick) begin
                  d.cap_cnt = q.cap_cnt + 1'b1;
               end
            end else if (!cap_above_thresh) begin
               d.tmr = 32'h0;
               d.st = (q.grace != 32'h0) ? ST_GRACE : ST_CLOSE;
            end
         end
         ST_IDLE: begin
            if (active) begin
               // Enabling by pins skips the grace period
               d.tmr = 32'h0;
               d.st = ST_CLOSE;
            end
         end
         ST_GRACE: begin
            if (!active) begin
               d.st = ST_IDLE;
            end else if (kick_fall) begin
               d.tmr = 32'h0;
               d.st = ST_CLOSE;
            end else if (tick && q.tmr + 32'h1 >= q.grace) begin
               d.tmr = 32'h0;
               d.fault_n = 1'b0;
               d.last_fault = FLT_LATE;
               d.st = ST_FAULT;
            end
         end
         ST_CLOSE: begin
            if (!active) begin
               d.st = ST_IDLE;
            end else if (kick_fall) begin
               // Host broke the close window
               d.tmr = 32'h0;
               d.fault_n = 1'b0;
               d.last_fault = FLT_EARLY;
               d.st = ST_FAULT;
            end else if (cfg_change) begin
               d.tmr = 32'h0;
            end else if (tick && q.tmr + 32'h1 >= close_ticks) begin
               d.tmr = 32'h0;
               d.st = ST_OPEN;
            end
         end
         ST_OPEN: begin
            if (!active) begin
               d.st = ST_IDLE;
            end else if (kick_fall) begin
               d.tmr = 32'h0;
               d.st = ST_CLOSE;
            end else if (cfg_change) begin
               d.tmr = 32'h0;
               d.st = ST_CLOSE;
            end else if (tick && q.tmr + 32'h1 >= open_ticks) begin
               d.tmr = 32'h0;
               d.fault_n = 1'b0;
               d.last_fault = FLT_LATE;
               d.st = ST_FAULT;
            end
         end
         ST_FAULT: begin
            if (!active) begin
               // Output released at once when monitoring stops
               d.fault_n = 1'b1;
               d.st = ST_IDLE;
            end else if (tick && q.tmr + 32'h1 >= q.fault_time) begin
               d.fault_n = 1'b1;
               d.tmr = 32'h0;
               d.st = (q.grace != 32'h0) ? ST_GRACE : ST_CLOSE;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      // Leaving measurement is decided there; other states wait on the enable
      if (q.st == ST_MEAS && !q.charge && !cap_above_thresh && PIN_CFG != CFG_EN_PIN
         && (q.cap_err || !active)) begin
         d.st = ST_IDLE;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q.st <= (PIN_CFG == CFG_EN_PIN) ? ST_CLOSE : ST_MEAS;
         q.presc <= 8'h00;
         q.tmr <= 32'h0;
         q.kick_s1 <= 1'b1;
         q.kick_s2 <= 1'b1;
         q.kick_s3 <= 1'b1;
         q.cap_cnt <= '0;
         q.cap_err <= 1'b0;
         q.charge <= (PIN_CFG != CFG_EN_PIN);
         q.ratio <= RST_RATIO;
         q.close_fix <= RST_CLOSE_FIX;
         q.grace <= RST_GRACE;
         q.fault_time <= RST_FAULT_TIME;
         q.prev_close <= 32'h0;
         q.prev_open <= 32'h0;
         q.prev_en <= 1'b0;
         q.last_fault <= FLT_NONE;
         q.rdata <= 32'h0;
         q.fault_n <= 1'b1;
      end else begin
         q <= d;
      end
   end
endmodule

// file: tb/wwd_host_model.sv
`timescale 1ns/1ps
// Host side: makes one kick pulse per request
module wwd_host_model #(
   parameter int HOLD_CYC = 100
) (
   // Clock
   input wire logic ref_clk,
   // Request from the bench
   input wire logic kick_req,
   // Kick pin
   output logic kick_input
);
   int cnt = 0; // Low cycles still to hold
   // Pin idles high; a request pulls it low for a full pulse
   always @(posedge ref_clk) begin
      if (kick_req && cnt == 0) begin
         kick_input <= 1'b0;
         cnt <= HOLD_CYC;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         // Rise only after 500 ns so the edge is never missed; idle level otherwise,
         // already set at the first edge, long before reset ends
         kick_input <= 1'b1;
         cnt <= 0;
      end
   end
endmodule

// file: tb/wwd_properties.sv
`timescale 1ns/1ps
// Port-level checks on the watchdog top
module wwd_properties import wwd_pkg::*; #(
   parameter int PIN_CFG = CFG_TWO_SEL
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Supervisory and watchdog pins
   input wire logic supply_valid,
   input wire logic manual_reset_n,
   input wire logic kick_input,
   input wire logic watchdog_enable_pin,
   input wire logic ratio_select_lo,
   input wire logic ratio_select_hi,
   input wire logic fault_output_n,
   input wire logic close_window_cap_pin,
   input wire logic cap_above_thresh
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Monitoring allowed; enable pin on the pin variant, disable code on the two-select one
   logic act;
   assign act = supply_valid && manual_reset_n
      && (PIN_CFG != CFG_EN_PIN || watchdog_enable_pin)
      && (PIN_CFG != CFG_TWO_SEL || {ratio_select_hi, ratio_select_lo} != SEL_DISABLE);
   // Access phase of any transfer
   sequence s_access;
      psel && penable;
   endsequence
   // Access past the last register word
   sequence s_unmapped;
      s_access ##0 (paddr > OFS_STATUS);
   endsequence
   // Start of a fault pulse
   sequence s_fault_start;
      $fell(fault_output_n);
   endsequence
   AST_PREADY_NO_WAIT: assert property (s_access |-> pready)
      else $error("pready low in access phase");
   AST_UNMAPPED_ERR: assert property (s_unmapped |-> pslverr)
      else $error("no slave error on unmapped address");
   // Only aligned words up to the status register are mapped
   AST_MAPPED_OK: assert property (s_access ##0 (paddr <= OFS_STATUS && paddr[1:0] == 2'h0)
      |-> !pslverr)
      else $error("slave error on mapped address");
   AST_INACTIVE_RELEASED: assert property ((!supply_valid || !manual_reset_n) [*3] |-> fault_output_n)
      else $error("fault output low while monitoring is off");
   AST_DISABLE_RELEASED: assert property ((PIN_CFG == CFG_EN_PIN && !watchdog_enable_pin) [*3] |-> fault_output_n)
      else $error("fault output low while disabled");
   // A pulse lasts at least eight cycles unless monitoring stops
   AST_FAULT_HOLD: assert property (s_fault_start |-> (!fault_output_n || !act) [*8])
      else $error("fault pulse too short");
   AST_RESET_RELEASED: assert property ($rose(rstn) |-> fault_output_n)
      else $error("fault output low after reset");
   AST_NO_CAP_DRIVE: assert property (PIN_CFG == CFG_EN_PIN |-> !close_window_cap_pin)
      else $error("capacitor driven on fixed-window variant");
endmodule
bind wwd_top wwd_properties #(.PIN_CFG(PIN_CFG)) u_wwd_properties (.ref_clk(ref_clk),
   .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .supply_valid(supply_valid), .manual_reset_n(manual_reset_n), .kick_input(kick_input),
   .watchdog_enable_pin(watchdog_enable_pin), .ratio_select_lo(ratio_select_lo),
   .ratio_select_hi(ratio_select_hi), .fault_output_n(fault_output_n),
   .close_window_cap_pin(close_window_cap_pin), .cap_above_thresh(cap_above_thresh));

// file: tb/wwd_tb_top.sv
`timescale 1ns/1ps
// Bench for the fixed-window variant with enable pin
module wwd_tb_top import wwd_pkg::*; ;
   typedef struct packed {logic [33:0] e; logic [33:0] m;} wwd_note_t;
   localparam int FT = 4; // Fault time, ticks
   // Design pins
   logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, kick_input, fault_output_n, close_window_cap_pin;
   logic supply_valid = 1, manual_reset_n = 1, watchdog_enable_pin = 0;
   logic ratio_select_lo = 0, ratio_select_hi = 0, kick_req = 0;
   // Bench state
   wwd_note_t notes[$];
   wwd_note_t n;
   int n_errors = 0, checks = 0, cw;
   logic [31:0] seed;
   logic [7:0] ua;
   wwd_top #(.PIN_CFG(CFG_EN_PIN)) u_wwd_top (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .supply_valid(supply_valid),
      .manual_reset_n(manual_reset_n), .kick_input(kick_input),
      .watchdog_enable_pin(watchdog_enable_pin), .ratio_select_lo(ratio_select_lo),
      .ratio_select_hi(ratio_select_hi), .fault_output_n(fault_output_n),
      .close_window_cap_pin(close_window_cap_pin), .cap_above_thresh(1'b0));
   wwd_host_model u_wwd_host_model (.ref_clk(ref_clk), .kick_req(kick_req),
      .kick_input(kick_input));
   // 200 MHz clock
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Verdict and end of run
   task automatic end_of_test();
      if (n_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One APB transfer, then an idle cycle so strobes never change twice at one edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0; penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Read noting {pslverr, fault pin, data} and a compare mask
   task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
      notes.push_back('{e, m});
      apb(1'b0, a, 32'h0);
   endtask
   // Full-word read of a mapped register
   task automatic rdv(input logic [7:0] a, input logic [31:0] d);
      rd(a, {2'h1, d}, {34{1'b1}});
   endtask
   // Status read; a fault kind of 3 means any
   // Two edges first: the state is latched at the setup edge, so a pin change made just
   // before must have moved the state machine by then
   task automatic st(input logic [5:0] s, input logic [1:0] f, input logic fn);
      repeat (2) @(posedge ref_clk);
      rd(OFS_STATUS, {1'b0, fn, 24'h0, f, s}, {2'h3, 24'h0, (f == 2'h3) ? 2'h0 : 2'h3, 6'h3f});
   endtask
   // Waits in half close windows and in ticks
   task automatic wc(input int h);
      repeat (h * cw * TICK_CYC / 2) @(posedge ref_clk);
   endtask
   task automatic wt(input int t);
      repeat (t * TICK_CYC) @(posedge ref_clk);
   endtask
   // Ask the host for a kick and let it reach the state machine
   task automatic kick();
      kick_req <= 1'b1;
      @(posedge ref_clk);
      kick_req <= 1'b0;
      repeat (20) @(posedge ref_clk);
   endtask
   // Read data is taken at the rising edge that completes the access phase
   always @(posedge ref_clk) begin
      if (psel && penable && pready && !pwrite) begin
         checks++;
         if (notes.size() == 0) begin
            n_errors++;
            $display("[ERR] read %h exp none got %h", paddr, prdata);
         end else begin
            n = notes.pop_front();
            if ((({pslverr, fault_output_n, prdata} ^ n.e) & n.m) !== 34'h0) begin
               n_errors++;
               $display("[ERR] read %h exp %h got %h", paddr, n.e,
                  {pslverr, fault_output_n, prdata});
            end
         end
      end
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      end_of_test();
   end
   // Main sequence
   initial begin
      seed = 32'hfa82;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rdv(OFS_RATIO, 32'(RST_RATIO));
      rdv(OFS_CLOSE_FIX, RST_CLOSE_FIX);
      rdv(OFS_GRACE, RST_GRACE);
      rdv(OFS_FAULT_TIME, RST_FAULT_TIME);
      st(ST_IDLE, FLT_NONE, 1'b1);
      // Unmapped word: write ignored, reads zero with error
      ua = 8'h14 | (8'($random(seed)) & 8'he0);
      apb(1'b1, ua, $random(seed));
      rd(ua, {2'h3, 32'h0}, {34{1'b1}});
      cw = 6 + ($random(seed) & 3);
      apb(1'b1, OFS_CLOSE_FIX, 32'(cw));
      apb(1'b1, OFS_FAULT_TIME, 32'(FT));
      rdv(OFS_CLOSE_FIX, 32'(cw));
      rdv(OFS_FAULT_TIME, 32'(FT));
      watchdog_enable_pin <= 1'b1;
      st(ST_CLOSE, FLT_NONE, 1'b1);
      wc(1);
      st(ST_CLOSE, FLT_NONE, 1'b1);
      wc(2);
      st(ST_OPEN, FLT_NONE, 1'b1);
      kick();
      st(ST_CLOSE, FLT_NONE, 1'b1);
      // No kick at all: late fault after two windows
      wc(4);
      wt(FT / 2);
      st(ST_FAULT, FLT_LATE, 1'b0);
      wt(FT);
      st(ST_CLOSE, FLT_LATE, 1'b1);
      kick();
      st(ST_FAULT, FLT_EARLY, 1'b0);
      watchdog_enable_pin <= 1'b0;
      st(ST_IDLE, 2'h3, 1'b1);
      wc(1);
      st(ST_IDLE, 2'h3, 1'b1);
      watchdog_enable_pin <= 1'b1;
      st(ST_CLOSE, 2'h3, 1'b1);
      wc(1);
      wc(2);
      st(ST_OPEN, 2'h3, 1'b1);
      // Walk every select code; each change restarts the frame
      ratio_select_hi <= 1'b1;
      st(ST_CLOSE, 2'h3, 1'b1);
      wc(5);
      st(ST_OPEN, 2'h3, 1'b1);
      ratio_select_lo <= 1'b1;
      st(ST_CLOSE, 2'h3, 1'b1);
      wc(5);
      st(ST_OPEN, 2'h3, 1'b1);
      ratio_select_hi <= 1'b0;
      st(ST_CLOSE, 2'h3, 1'b1);
      wc(3);
      st(ST_OPEN, 2'h3, 1'b1);
      wc(1);
      wt(2);
      st(ST_FAULT, FLT_LATE, 1'b0);
      manual_reset_n <= 1'b0;
      st(ST_IDLE, 2'h3, 1'b1);
      manual_reset_n <= 1'b1;
      st(ST_CLOSE, 2'h3, 1'b1);
      supply_valid <= 1'b0;
      st(ST_IDLE, 2'h3, 1'b1);
      supply_valid <= 1'b1;
      st(ST_CLOSE, 2'h3, 1'b1);
      end_of_test();
   end
endmodule
